/* File: verilog/saad_pkg.sv */
// Purpose: shared constants for the sink auxiliary packet and audio decoder
// Assumes: packet type codes follow the usual auxiliary packet numbering
// Notes: masks clear the reserved bits of the captured field outputs
package saad_pkg;
	localparam int WORD_W = 72;
	localparam int ADDR_W = 7;
	localparam int PKT_WORDS = 4;
	localparam logic [1:0] LAST_WORD = 2'h3;
	localparam logic [ADDR_W-1:0] REGION_STEP = 7'h04;
	// packet type codes carried in header byte zero
	localparam logic [7:0] TYPE_ACR = 8'h01;
	localparam logic [7:0] TYPE_AUDIO = 8'h02;
	localparam logic [7:0] TYPE_CONTROL = 8'h03;
	localparam logic [7:0] TYPE_ONEBIT = 8'h07;
	localparam logic [7:0] TYPE_DST = 8'h08;
	localparam logic [7:0] TYPE_HBR = 8'h09;
	localparam logic [7:0] TYPE_3D = 8'h0B;
	localparam logic [7:0] TYPE_ONEBIT_3D = 8'h0C;
	localparam logic [7:0] TYPE_META = 8'h0D;
	localparam logic [7:0] TYPE_MS = 8'h0E;
	localparam logic [7:0] TYPE_ONEBIT_MS = 8'h0F;
	localparam logic [7:0] TYPE_LAST_LOW = 8'h0F;
	localparam logic [7:0] TYPE_VENDOR = 8'h81;
	localparam logic [7:0] TYPE_VIDEO = 8'h82;
	localparam logic [7:0] TYPE_SPD = 8'h83;
	localparam logic [7:0] TYPE_AIF = 8'h84;
	localparam logic [7:0] TYPE_MPEG = 8'h85;
	localparam logic [7:0] TYPE_TSC_VBI = 8'h86;
	localparam logic [7:0] TYPE_DRM = 8'h87;
	// region start addresses for the infoframes
	localparam logic [ADDR_W-1:0] ADDR_VENDOR = 7'h40;
	localparam logic [ADDR_W-1:0] ADDR_VIDEO = 7'h44;
	localparam logic [ADDR_W-1:0] ADDR_SPD = 7'h48;
	localparam logic [ADDR_W-1:0] ADDR_AIF = 7'h4C;
	localparam logic [ADDR_W-1:0] ADDR_MPEG = 7'h50;
	localparam logic [ADDR_W-1:0] ADDR_TSC_VBI = 7'h54;
	localparam logic [ADDR_W-1:0] ADDR_DRM = 7'h58;
	// captured field masks, reserved bits cleared
	localparam logic [23:0] CONTROL_MASK = 24'h01_FF_11;
	localparam logic [103:0] VIDEO_MASK = 104'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF_7F;
	localparam logic [63:0] VENDOR_MASK = 64'hFFFF_F0FF_E0FF_FFFF;
	localparam logic [79:0] AIF_MASK = 80'h0000_0000_03FB_FFFF_1FF7;
	localparam logic [79:0] META_MASK = 80'hFFFF_FFFF_FFFF_FFFF_FFFF;
	localparam int PHASE_W = 32;
	localparam logic [7:0] ACR_DIV = 8'h80;
	localparam logic [2:0] SAMPLE_SLOTS = 3'h4;
endpackage : saad_pkg

/* File: verilog/saad_decoder.sv */
// Purpose: sink auxiliary packet writer, packet capture and audio depacketizer
// Assumes: mclk is the auxiliary stream clock, carrying SYMBOLS_PER_CLK link
//   characters per cycle; the packet memory never stalls
// Notes: no parity checking or correction is done; words pass as received
`timescale 1ns/1ps
module saad_decoder #(
	parameter int SYMBOLS_PER_CLK = 1,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic mclk, // block clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic [71:0] aux_data, // auxiliary word
	input wire logic aux_valid, // word qualifier
	input wire logic aux_sop, // first word of packet
	input wire logic aux_eop, // last word of packet
	output logic mem_wr_q, // packet memory write strobe
	output logic [6:0] mem_addr_q, // packet memory word address
	output logic [71:0] mem_wdata_q, // packet memory write data
	output logic [23:0] general_control_packet_q, // control packet bytes 2..0
	output logic [103:0] video_info_frame_q, // video frame bytes 13..1
	output logic [63:0] vendor_info_frame_q, // vendor frame bytes 8..1
	output logic [79:0] aif_fields_q, // audio infoframe bytes 10..1
	output logic [79:0] meta_fields_q, // audio metadata bytes 9..0
	output logic [19:0] acr_cts_q, // cycle time stamp
	output logic [19:0] acr_n_q, // audio clock divider N
	output logic [3:0] audio_format_q, // type code of last audio packet
	output logic audio_valid_q, // recovered audio rate pulse
	output logic [31:0] audio_left_q, // left sample word
	output logic [31:0] audio_right_q, // right sample word
	output logic audio_overflow_q // sticky: sample dropped on full FIFO
);
	localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
	localparam int PTR_W = $clog2(FIFO_DEPTH);

	typedef enum logic [1:0] {
		SAAD_IDLE = 2'b01,
		SAAD_BODY = 2'b10
	} saad_state_t;

	saad_state_t state_q;
	logic [1:0] word_idx_q;
	logic [6:0] base_q;
	logic region_ok_q;
	logic [71:0] pkt_q [0:2];
	logic [287:0] whole;
	logic [7:0] header_byte_zero;
	logic pkt_done;
	logic [7:0] start_region;
	logic [6:0] start_base;
	logic start_ok;

	// payload byte p lives in subpacket p/7, byte p%7 of it
	function automatic logic [7:0] pb(input logic [287:0] w, input int p);
		int s;
		int k;
		int wd;
		int off;
		s = p / 7;
		k = p % 7;
		if (k == 6) begin
			wd = 3;
			off = 1 + 2 * s;
		end else begin
			wd = k / 2;
			off = 1 + 2 * s + (k % 2);
		end
		return w[wd * 72 + off * 8 +: 8];
	endfunction : pb

	function automatic logic [7:0] region(input logic [7:0] t);
		logic [7:0] r;
		r = 8'hFF;
		if (t <= saad_pkg::TYPE_LAST_LOW) begin
			r = {t[5:0], 2'b00};
		end
		case (t)
			saad_pkg::TYPE_VENDOR: r = {1'b0, saad_pkg::ADDR_VENDOR};
			saad_pkg::TYPE_VIDEO: r = {1'b0, saad_pkg::ADDR_VIDEO};
			saad_pkg::TYPE_SPD: r = {1'b0, saad_pkg::ADDR_SPD};
			saad_pkg::TYPE_AIF: r = {1'b0, saad_pkg::ADDR_AIF};
			saad_pkg::TYPE_MPEG: r = {1'b0, saad_pkg::ADDR_MPEG};
			saad_pkg::TYPE_TSC_VBI: r = {1'b0, saad_pkg::ADDR_TSC_VBI};
			saad_pkg::TYPE_DRM: r = {1'b0, saad_pkg::ADDR_DRM};
			default: ;
		endcase
		return r;
	endfunction : region

	function automatic logic is_audio(input logic [7:0] t);
		return t == saad_pkg::TYPE_AUDIO || t == saad_pkg::TYPE_ONEBIT ||
			t == saad_pkg::TYPE_DST || t == saad_pkg::TYPE_HBR ||
			t == saad_pkg::TYPE_3D || t == saad_pkg::TYPE_ONEBIT_3D ||
			t == saad_pkg::TYPE_MS || t == saad_pkg::TYPE_ONEBIT_MS;
	endfunction : is_audio

	assign start_region = region(aux_data[7:0]);
	assign start_base = start_region[6:0];
	assign start_ok = start_region != 8'hFF;
	// last word kept exactly as received
	assign whole = {aux_data, pkt_q[2], pkt_q[1], pkt_q[0]};
	assign header_byte_zero = pkt_q[0][7:0];
	// only a four-word packet ending on word 3 counts
	assign pkt_done = aux_valid && aux_eop && state_q == SAAD_BODY
		&& word_idx_q == saad_pkg::LAST_WORD;

	// framing: start marker restarts, end marker closes
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= SAAD_IDLE;
			word_idx_q <= 2'h0;
			base_q <= 7'h00;
			region_ok_q <= 1'b0;
		end else if (aux_valid) begin
			case (state_q)
				SAAD_IDLE: begin
					if (aux_sop && !aux_eop) begin
						state_q <= SAAD_BODY;
						word_idx_q <= 2'h1;
						base_q <= start_base;
						region_ok_q <= start_ok;
					end
				end
				SAAD_BODY: begin
					if (aux_sop) begin
						word_idx_q <= 2'h1;
						base_q <= start_base;
						region_ok_q <= start_ok;
					end else if (aux_eop || word_idx_q == saad_pkg::LAST_WORD) begin
						state_q <= SAAD_IDLE;
						word_idx_q <= 2'h0;
					end else begin
						word_idx_q <= word_idx_q + 2'h1;
					end
				end
				default: begin
					state_q <= SAAD_IDLE;
					word_idx_q <= 2'h0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pkt_q[0] <= '0;
			pkt_q[1] <= '0;
			pkt_q[2] <= '0;
		end else if (aux_valid) begin
			if (aux_sop) begin
				pkt_q[0] <= aux_data;
			end else if (state_q == SAAD_BODY && word_idx_q != saad_pkg::LAST_WORD) begin
				pkt_q[word_idx_q] <= aux_data;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mem_wr_q <= 1'b0;
			mem_addr_q <= 7'h00;
			mem_wdata_q <= '0;
		end else begin
			mem_wr_q <= 1'b0;
			mem_wdata_q <= aux_data;
			if (aux_valid && aux_sop) begin
				mem_wr_q <= start_ok;
				mem_addr_q <= start_base;
			end else if (aux_valid && state_q == SAAD_BODY) begin
				// one write per cycle, never stalled
				mem_wr_q <= region_ok_q;
				mem_addr_q <= base_q + {5'h00, word_idx_q};
			end
		end
	end

	// captured packets held until the next of the same type
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			general_control_packet_q <= '0;
			video_info_frame_q <= '0;
			vendor_info_frame_q <= '0;
		end else if (pkt_done) begin
			if (header_byte_zero == saad_pkg::TYPE_CONTROL) begin
				for (int i = 0; i < 3; i++) begin
					general_control_packet_q[i * 8 +: 8] <=
						pb(whole, i) & saad_pkg::CONTROL_MASK[i * 8 +: 8];
				end
			end
			// checksum byte zero is a control byte, so infoframes start at byte 1
			if (header_byte_zero == saad_pkg::TYPE_VIDEO) begin
				for (int i = 0; i < 13; i++) begin
					video_info_frame_q[i * 8 +: 8] <=
						pb(whole, i + 1) & saad_pkg::VIDEO_MASK[i * 8 +: 8];
				end
			end
			if (header_byte_zero == saad_pkg::TYPE_VENDOR) begin
				for (int i = 0; i < 8; i++) begin
					vendor_info_frame_q[i * 8 +: 8] <=
						pb(whole, i + 1) & saad_pkg::VENDOR_MASK[i * 8 +: 8];
				end
			end
		end
	end

	// audio infoframe and metadata presented only
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			aif_fields_q <= '0;
			meta_fields_q <= '0;
		end else if (pkt_done) begin
			if (header_byte_zero == saad_pkg::TYPE_AIF) begin
				for (int i = 0; i < 10; i++) begin
					aif_fields_q[i * 8 +: 8] <= pb(whole, i + 1) & saad_pkg::AIF_MASK[i * 8 +: 8];
				end
			end
			if (header_byte_zero == saad_pkg::TYPE_META) begin
				for (int i = 0; i < 10; i++) begin
					meta_fields_q[i * 8 +: 8] <= pb(whole, i) & saad_pkg::META_MASK[i * 8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			acr_cts_q <= 20'h00000;
			acr_n_q <= 20'h00000;
			audio_format_q <= 4'h0;
		end else if (pkt_done) begin
			if (header_byte_zero == saad_pkg::TYPE_ACR) begin
				acr_cts_q <= 20'({pb(whole, 1), pb(whole, 2), pb(whole, 3)});
				acr_n_q <= 20'({pb(whole, 4), pb(whole, 5), pb(whole, 6)});
			end
			// format is the audio packet type
			if (is_audio(header_byte_zero)) begin
				audio_format_q <= header_byte_zero[3:0];
			end
		end
	end

	// phase counter: each cycle carries SYMBOLS_PER_CLK characters
	// and the sample rate is chars * N / (128 * CTS)
	logic [saad_pkg::PHASE_W-1:0] phase_q;
	logic [saad_pkg::PHASE_W-1:0] phase_inc;
	logic [saad_pkg::PHASE_W-1:0] phase_thr;
	logic [saad_pkg::PHASE_W-1:0] phase_sum;
	logic tick;
	assign phase_inc = saad_pkg::PHASE_W'(acr_n_q) * saad_pkg::PHASE_W'(SYMBOLS_PER_CLK);
	assign phase_thr = saad_pkg::PHASE_W'(acr_cts_q) * saad_pkg::PHASE_W'(saad_pkg::ACR_DIV);
	assign phase_sum = phase_q + phase_inc;
	assign tick = acr_cts_q != 20'h00000 && phase_sum >= phase_thr;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			phase_q <= '0;
			audio_valid_q <= 1'b0;
		end else begin
			audio_valid_q <= tick;
			if (acr_cts_q == 20'h00000) begin
				phase_q <= '0;
			end else if (tick) begin
				phase_q <= phase_sum - phase_thr;
			end else begin
				phase_q <= phase_sum;
			end
		end
	end

	// staged samples walked into the FIFO, one subpacket a cycle
	// four cycles fit inside the shortest following packet
	logic [63:0] stage_q [0:3];
	logic [3:0] present_q;
	logic [2:0] slot_q;
	logic push;
	logic [63:0] push_data;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			present_q <= 4'h0;
			slot_q <= saad_pkg::SAMPLE_SLOTS;
			for (int s = 0; s < 4; s++) begin
				stage_q[s] <= '0;
			end
		end else if (pkt_done && header_byte_zero == saad_pkg::TYPE_AUDIO) begin
			// sample_present bits of header byte 1
			present_q <= pkt_q[1][3:0];
			slot_q <= 3'h0;
			for (int s = 0; s < 4; s++) begin
				stage_q[s] <= {pb(whole, s * 7 + 6) & 8'hF0,
					pb(whole, s * 7 + 5), pb(whole, s * 7 + 4), pb(whole, s * 7 + 3),
					pb(whole, s * 7 + 6) << 4,
					pb(whole, s * 7 + 2), pb(whole, s * 7 + 1), pb(whole, s * 7)};
			end
		end else if (slot_q != saad_pkg::SAMPLE_SLOTS) begin
			slot_q <= slot_q + 3'h1;
		end
	end

	assign push = slot_q != saad_pkg::SAMPLE_SLOTS && present_q[slot_q[1:0]];
	assign push_data = stage_q[slot_q[1:0]];

	// sample FIFO, left word in the low half
	logic [63:0] fifo_q [0:FIFO_DEPTH-1];
	logic [PTR_W-1:0] wr_ptr_q;
	logic [PTR_W-1:0] rd_ptr_q;
	logic [CNT_W-1:0] count_q;
	logic fifo_full;
	logic fifo_empty;
	logic do_push;
	logic do_pop;
	assign fifo_full = count_q == CNT_W'(FIFO_DEPTH);
	assign fifo_empty = count_q == '0;
	assign do_push = push && !fifo_full;
	assign do_pop = tick && !fifo_empty;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_q <= (wr_ptr_q == PTR_W'(FIFO_DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (do_pop) begin
				rd_ptr_q <= (rd_ptr_q == PTR_W'(FIFO_DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			end
			if (do_push && !do_pop) begin
				count_q <= count_q + 1'b1;
			end else if (do_pop && !do_push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (do_push) begin
			fifo_q[wr_ptr_q] <= push_data;
		end
	end

	// samples hold their last value when the pulse finds the FIFO empty
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			audio_left_q <= 32'h00000000;
			audio_right_q <= 32'h00000000;
			audio_overflow_q <= 1'b0;
		end else begin
			if (do_pop) begin
				audio_left_q <= fifo_q[rd_ptr_q][31:0];
				audio_right_q <= fifo_q[rd_ptr_q][63:32];
			end
			if (push && fifo_full) begin
				audio_overflow_q <= 1'b1;
			end
		end
	end
endmodule : saad_decoder

/* File: tb/saad_decoder_asserts.sv */
// Purpose: port checks for the auxiliary packet decoder
// Assumes: one clock, synchronous active-low reset
// Notes: last_addr_q keeps the address of the previous memory write
`timescale 1ns/1ps
module saad_decoder_asserts (
	input wire logic mclk, // clock
	input wire logic rst_n, // reset
	input wire logic [71:0] aux_data, // word
	input wire logic aux_valid, // qualifier
	input wire logic aux_sop, // first word
	input wire logic aux_eop, // last word
	input wire logic mem_wr_q, // strobe
	input wire logic [6:0] mem_addr_q, // address
	input wire logic [71:0] mem_wdata_q, // data
	input wire logic [23:0] general_control_packet_q, // control fields
	input wire logic [79:0] aif_fields_q, // audio frame
	input wire logic [19:0] acr_cts_q, // time stamp
	input wire logic audio_valid_q, // rate pulse
	input wire logic [31:0] audio_left_q, // left word
	input wire logic audio_overflow_q // drop flag
);
	logic [6:0] last_addr_q;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge mclk) begin
		if (!rst_n)
			last_addr_q <= 7'h00;
		else if (mem_wr_q)
			last_addr_q <= mem_addr_q;
	end
	function automatic logic [6:0] region_of(input logic [7:0] t);
		return t[7] ? 7'h3C + {2'h0, t[2:0], 2'h0} : {t[4:0], 2'h0};
	endfunction : region_of
	property p_wr_cause;
		mem_wr_q |-> $past(aux_valid);
	endproperty
	a_wr_cause: assert property (p_wr_cause) else $error("write without word");
	property p_data_raw;
		mem_wr_q |-> mem_wdata_q == $past(aux_data);
	endproperty
	a_data_raw: assert property (p_data_raw) else $error("word altered");
	property p_first_addr;
		mem_wr_q && $past(aux_sop) |-> mem_addr_q == region_of($past(aux_data[7:0]));
	endproperty
	a_first_addr: assert property (p_first_addr) else $error("bad region");
	property p_next_addr;
		mem_wr_q && !$past(aux_sop) |-> mem_addr_q == last_addr_q + 7'h01;
	endproperty
	a_next_addr: assert property (p_next_addr) else $error("word not consecutive");
	property p_reserved;
		(general_control_packet_q & ~saad_pkg::CONTROL_MASK) == 24'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");
	property p_aif_reserved;
		(aif_fields_q & ~saad_pkg::AIF_MASK) == 80'h0;
	endproperty
	a_aif_reserved: assert property (p_aif_reserved) else $error("reserved bit set");
	property p_capture;
		!$stable(general_control_packet_q) |-> $past(aux_valid) && $past(aux_eop);
	endproperty
	a_capture: assert property (p_capture) else $error("capture without end");
	property p_silent;
		(acr_cts_q == 20'h00000) [*3] |-> !audio_valid_q;
	endproperty
	a_silent: assert property (p_silent) else $error("pulse while disabled");
	property p_hold;
		!audio_valid_q |-> $stable(audio_left_q);
	endproperty
	a_hold: assert property (p_hold) else $error("sample moved off pulse");
	property p_sticky;
		audio_overflow_q |=> audio_overflow_q;
	endproperty
	a_sticky: assert property (p_sticky) else $error("overflow cleared");
	c_pulse: cover property (audio_valid_q);
	c_ctrl: cover property (!$stable(general_control_packet_q));
	c_last: cover property (mem_wr_q && mem_addr_q == 7'h5B);
endmodule : saad_decoder_asserts

bind saad_decoder saad_decoder_asserts i_saad_decoder_asserts (.mclk, .rst_n, .aux_data,
	.aux_valid, .aux_sop, .aux_eop, .mem_wr_q, .mem_addr_q, .mem_wdata_q,
	.general_control_packet_q, .aif_fields_q, .acr_cts_q, .audio_valid_q, .audio_left_q,
	.audio_overflow_q);

/* File: tb/saad_mem_model.sv */
// Purpose: external packet memory
// Assumes: one write per clock, never stalls
// Notes: unwritten words stay unknown so stale reads fail
`timescale 1ns/1ps
module saad_mem_model (
	input wire logic mclk, // clock
	input wire logic wr, // strobe
	input wire logic [6:0] addr, // address
	input wire logic [71:0] wdata // data
);
	logic [71:0] mem [0:127];
	int n_writes = 0;
	always @(posedge mclk) begin
		if (wr === 1'b1) begin
			mem[addr] <= wdata;
			n_writes <= n_writes + 1;
		end
	end
endmodule : saad_mem_model

/* File: tb/tb_top.sv */
// Purpose: random and corner packets through the decoder
// Assumes: stream driven 2 ns after the rising edge
// Notes: audio runs first while the sample FIFO is known empty
`timescale 1ns/1ps
module tb_top;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [71:0] aux_data = 72'h0;
	logic aux_valid = 1'b0;
	logic aux_sop = 1'b0;
	logic aux_eop = 1'b0;
	logic mem_wr_q, audio_valid_q, audio_overflow_q;
	logic [6:0] mem_addr_q;
	logic [71:0] mem_wdata_q;
	logic [23:0] general_control_packet_q;
	logic [103:0] video_info_frame_q;
	logic [63:0] vendor_info_frame_q;
	logic [79:0] aif_fields_q, meta_fields_q;
	logic [19:0] acr_cts_q, acr_n_q;
	logic [3:0] audio_format_q;
	logic [31:0] audio_left_q, audio_right_q;
	logic [31:0] seed = 32'h0000_27B9;
	logic [7:0] hb [3];
	logic [7:0] pb [28];
	logic [71:0] w [4];
	logic [31:0] exp_l [$];
	logic [31:0] exp_r [$];
	int n_tests = 0;
	int n_fail = 0;
	always #25 mclk = ~mclk;
	saad_decoder #(.SYMBOLS_PER_CLK(1), .FIFO_DEPTH(16)) i_saad_decoder (.mclk, .rst_n,
		.aux_data, .aux_valid, .aux_sop, .aux_eop, .mem_wr_q, .mem_addr_q, .mem_wdata_q,
		.general_control_packet_q, .video_info_frame_q, .vendor_info_frame_q,
		.aif_fields_q, .meta_fields_q,
		.acr_cts_q, .acr_n_q, .audio_format_q, .audio_valid_q, .audio_left_q,
		.audio_right_q, .audio_overflow_q);
	saad_mem_model i_saad_mem_model (.mclk, .wr(mem_wr_q), .addr(mem_addr_q),
		.wdata(mem_wdata_q));
	function automatic logic [31:0] rnd;
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [103:0] cat(input int lo, input int n);
		logic [103:0] r = '0;
		for (int i = n - 1; i >= 0; i--) r = {r[95:0], pb[lo + i]};
		return r;
	endfunction : cat
	task automatic chk(input logic [103:0] got, input logic [103:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic idle(input int n);
		aux_valid = 1'b0;
		repeat (n) @(posedge mclk);
		#2;
	endtask : idle
	task automatic send(input logic [7:0] t, input logic [7:0] h1);
		logic [95:0] r;
		hb[0] = t;
		hb[1] = h1;
		hb[2] = 8'(rnd());
		for (int i = 0; i < 4; i++) begin
			r = {rnd(), rnd(), rnd()};
			w[i] = r[71:0];
			if (i < 3)
				w[i][7:0] = hb[i];
		end
		for (int n = 0; n < 28; n++) begin
			if (n % 7 == 6)
				w[3][8 * (1 + 2 * (n / 7)) +: 8] = pb[n];
			else
				w[(n % 7) / 2][8 * (1 + 2 * (n / 7) + (n % 7) % 2) +: 8] = pb[n];
		end
		for (int k = 0; k < 4; k++) begin
			aux_valid = 1'b1;
			aux_sop = (k == 0);
			aux_eop = (k == 3);
			aux_data = w[k];
			@(posedge mclk);
			#2;
		end
	endtask : send
	task automatic pop(input logic [31:0] l, input logic [31:0] r);
		int i = 0;
		while (audio_valid_q !== 1'b1 && i < 99) begin
			@(posedge mclk);
			#2;
			i++;
		end
		chk(104'(i < 99), 104'h1);
		chk(104'(audio_left_q), 104'(l));
		chk(104'(audio_right_q), 104'(r));
		@(posedge mclk);
		#2;
	endtask : pop
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out
	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		close_out();
	end
	initial begin
		logic [7:0] ty;
		logic [31:0] l, r;
		int n;
		repeat (8) @(posedge mclk);
		#2;
		rst_n = 1'b1;
		idle(2);
		for (int p = 0; p < 4; p++) begin
			for (int j = 0; j < 28; j++) pb[j] = 8'(rnd());
			send(8'h02, p == 0 ? 8'h0F : p == 1 ? 8'h01 : 8'(rnd()));
			for (int s = 0; s < 4; s++) begin
				if (hb[1][s]) begin
					exp_l.push_back({pb[7*s+6][3:0], 4'h0, pb[7*s+2], pb[7*s+1], pb[7*s]});
					exp_r.push_back({pb[7*s+6][7:4], 4'h0, pb[7*s+5], pb[7*s+4], pb[7*s+3]});
				end
			end
		end
		idle(8);
		chk(104'(audio_overflow_q), 104'h0);
		chk(104'(audio_format_q), 104'h2);
		for (int j = 0; j < 28; j++) pb[j] = 8'h00;
		pb[3] = 8'h01;
		pb[6] = 8'h40;
		send(8'h01, 8'h00);
		aux_valid = 1'b0;
		while (exp_l.size() > 0) begin
			l = exp_l.pop_front();
			r = exp_r.pop_front();
			pop(l, r);
		end
		pop(l, r);
		chk(104'(acr_cts_q), 104'h1);
		chk(104'(acr_n_q), 104'h40);
		pb[3] = 8'h00;
		send(8'h01, 8'h00);
		for (int p = 0; p < 5; p++) send(8'h02, 8'h0F);
		idle(8);
		chk(104'(audio_overflow_q), 104'h1);
		$display("audio test done");
		for (int i = 0; i < 23; i++) begin
			ty = (i < 16) ? 8'(i) : 8'h81 + 8'(i - 16);
			for (int j = 0; j < 28; j++) pb[j] = 8'(rnd());
			send(ty, 8'(rnd()));
			idle(2);
			n = ty[7] ? 60 + 4 * int'(ty[2:0]) : 4 * i;
			for (int k = 0; k < 4; k++) chk(104'(i_saad_mem_model.mem[n + k]), 104'(w[k]));
			if (ty inside {8'h02, 8'h07, 8'h08, 8'h09, 8'h0B, 8'h0C, 8'h0E, 8'h0F})
				chk(104'(audio_format_q), 104'(ty[3:0]));
			if (ty == 8'h03)
				chk(104'(general_control_packet_q), cat(0, 3) & 104'(saad_pkg::CONTROL_MASK));
			if (ty == 8'h82)
				chk(video_info_frame_q, cat(1, 13) & saad_pkg::VIDEO_MASK);
			if (ty == 8'h81)
				chk(104'(vendor_info_frame_q), cat(1, 8) & 104'(saad_pkg::VENDOR_MASK));
			if (ty == 8'h84)
				chk(104'(aif_fields_q), cat(1, 10) & 104'(saad_pkg::AIF_MASK));
			if (ty == 8'h0D)
				chk(104'(meta_fields_q), cat(0, 10) & 104'(saad_pkg::META_MASK));
			if (ty == 8'h01)
				chk(104'(acr_cts_q), 104'({pb[1][3:0], pb[2], pb[3]}));
		end
		$display("region test done");
		n = i_saad_mem_model.n_writes;
		send(8'h20, 8'h00);
		idle(3);
		chk(104'(i_saad_mem_model.n_writes), 104'(n));
		$display("refusal test done");
		// control packet cut after two words: written in part, never captured
		n = i_saad_mem_model.n_writes;
		l = 32'(general_control_packet_q);
		w[0] = {rnd(), rnd(), 8'h03};
		w[1] = {rnd(), rnd(), 8'h00};
		for (int k = 0; k < 2; k++) begin
			aux_valid = 1'b1;
			aux_sop = (k == 0);
			aux_eop = (k == 1);
			aux_data = w[k];
			@(posedge mclk);
			#2;
		end
		idle(3);
		chk(104'(i_saad_mem_model.n_writes), 104'(n + 2));
		chk(104'(i_saad_mem_model.mem[13]), 104'(w[1]));
		chk(104'(general_control_packet_q), 104'(l));
		$display("truncation test done");
		close_out();
	end
endmodule : tb_top
